// ### design/smpi_pin_front.sv
// Pin-level front end: select, edge capture and drive, protect and reset.
// Assumes core logic supplies tx groups and consumes rx groups.
`timescale 1ns/1ps
module smpi_pin_front (
   input wire logic clock,
   input wire logic rst,
   input wire smpi_pkg::smpi_pins_t pins,
   input wire smpi_pkg::smpi_tx_t tx,
   input wire logic [7:0] status1NonVolatile,
   input wire logic [7:0] config1Volatile,
   input wire logic [7:0] config2Volatile,
   input wire logic embeddedBusy,
   input wire logic wrarStatusTarget,
   input wire logic wrarStrobe,
   output smpi_pkg::smpi_drive_t drive,
   output logic [3:0] rxData,
   output logic rxValid,
   output logic txTake,
   output logic selected,
   output logic activePower,
   output logic wipFlag,
   output logic wrarAccept,
   output logic wrarIgnored,
   output logic hwReset
);
   import smpi_pkg::*;
   typedef struct packed {
      logic sckPrev;
      logic csPrev;
      logic armed;
      logic readSeen;
      logic [2:0] holdCnt;
      smpi_drive_t drv;
      logic [3:0] rx;
      logic rxV;
      logic take;
      logic sel;
      logic act;
      logic wip;
      logic acc;
      logic ign;
      logic hr;
   } smpi_front_st_t;
   smpi_front_st_t st_r;
   smpi_front_st_t st_nxt;
   logic [5:0] syncIn;
   logic sck;
   logic csN;
   logic [3:0] io;
   logic rise;
   logic fall;
   logic quadMode;
   logic protect;
   logic resetReq;

   smpi_sync #(.W(6)) u_sync (
      .clock(clock),
      .rst(rst),
      .async({pins.sck, pins.csN, pins.io}),
      .synced(syncIn)
   );
   assign {sck, csN, io} = syncIn;
   assign quadMode = config1Volatile[QUAD_ENABLE_BIT];

   smpi_reset_det u_rdet (
      .clock(clock),
      .rst(rst),
      .csN(csN),
      .pinLevel(io[3]),
      .resetEnable(config2Volatile[RESET_ENABLE_BIT]),
      .quadMode(quadMode),
      .resetReq(resetReq)
   );

   // Edges seen only while selected; a deselected device ignores the clock
   assign rise = !csN && st_r.armed && sck && !st_r.sckPrev;
   assign fall = !csN && st_r.armed && !sck && st_r.sckPrev;
   // Write protect is dropped when the pin serves as data line 2
   assign protect = !quadMode && !io[2] && status1NonVolatile[STATUS_WRITE_DISABLE_BIT];

   // Width to output-enable mask; lowest bit on line 0
   function automatic logic [3:0] widthMask(input smpi_width_t w);
      unique case (w)
         WIDTH_SINGLE: widthMask = 4'h2;
         WIDTH_DUAL: widthMask = 4'h3;
         WIDTH_QUAD: widthMask = 4'hF;
         default: widthMask = 4'h0;
      endcase
   endfunction : widthMask

   // Single next-state process for select, capture, drive and protect
   always_comb begin
      st_nxt = st_r;
      st_nxt.sckPrev = sck;
      st_nxt.csPrev = csN;
      st_nxt.rxV = 1'b0;
      st_nxt.take = 1'b0;
      st_nxt.acc = 1'b0;
      st_nxt.ign = 1'b0;
      st_nxt.hr = resetReq;
      st_nxt.sel = !csN;
      st_nxt.act = !csN || embeddedBusy;
      st_nxt.wip = embeddedBusy;
      // A chip select falling edge arms command acceptance unless resetReq arrives in the same cycle
      if (st_r.csPrev && !csN) begin
         st_nxt.armed = 1'b1;
         st_nxt.readSeen = 1'b0;
      end
      if (rise) begin
         st_nxt.rx = quadMode ? io : {2'b00, io[1:0]};
         st_nxt.rxV = 1'b1;
      end
      // Drive on fall for SDR, on every edge for DDR
      if (!csN && tx.readPhase && (fall || (tx.ddr && rise))) begin
         st_nxt.drv.ioOut = (tx.width == WIDTH_SINGLE) ? {2'b00, tx.data[0], 1'b0} : tx.data;
         st_nxt.drv.ioOeN = ~widthMask(tx.width);
         if (tx.width == WIDTH_QUAD && !quadMode) begin
            st_nxt.drv.ioOeN[3:2] = 2'b11;
         end
         st_nxt.take = 1'b1;
         st_nxt.readSeen = 1'b1;
      end else if (!csN && !tx.readPhase) begin
         st_nxt.drv.ioOeN = 4'hF;
      end
      // Quad read done: hold line 3 high briefly so pull-up lag is no reset
      if (csN) begin
         st_nxt.drv.ioOeN = 4'hF;
         if (st_r.readSeen && quadMode && st_r.holdCnt < 3'(CS_HOLD_DRIVE_CYCLES)) begin
            st_nxt.drv.ioOeN[3] = 1'b0;
            st_nxt.drv.ioOut[3] = 1'b1;
            st_nxt.holdCnt = st_r.holdCnt + 3'h1;
         end else begin
            st_nxt.readSeen = 1'b0;
         end
      end else begin
         st_nxt.holdCnt = 3'h0;
      end
      if (wrarStrobe && !csN) begin
         if (protect && wrarStatusTarget) begin
            st_nxt.ign = 1'b1;
         end else begin
            st_nxt.acc = 1'b1;
         end
      end
      if (resetReq) begin
         st_nxt.armed = 1'b0;
         st_nxt.readSeen = 1'b0;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         st_r <= '0;
         st_r.sckPrev <= 1'b0;
         st_r.csPrev <= 1'b1;
         st_r.drv.ioOeN <= 4'hF;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign drive = st_r.drv;
   assign rxData = st_r.rx;
   assign rxValid = st_r.rxV;
   assign txTake = st_r.take;
   assign selected = st_r.sel;
   assign activePower = st_r.act;
   assign wipFlag = st_r.wip;
   assign wrarAccept = st_r.acc;
   assign wrarIgnored = st_r.ign;
   assign hwReset = st_r.hr;

   deselect_hiz_a: assert property (@(posedge clock) disable iff (rst)
      csN && $past(csN) && !st_r.readSeen |=> st_r.drv.ioOeN == 4'hF)
      else $error("drivers active while deselected");
   active_power_a: assert property (@(posedge clock) disable iff (rst)
      !csN |=> activePower && selected)
      else $error("selected but not active");
   wip_flag_a: assert property (@(posedge clock) disable iff (rst)
      embeddedBusy |=> wipFlag)
      else $error("busy without write-in-progress");
   protect_block_a: assert property (@(posedge clock) disable iff (rst)
      wrarStrobe && !csN && protect && wrarStatusTarget |=> wrarIgnored && !wrarAccept)
      else $error("protected write accepted");
   capture_rise_a: assert property (@(posedge clock) disable iff (rst)
      rxValid |-> $past(rise))
      else $error("capture without rising edge");
   quad_no_reset_a: assert property (@(posedge clock) disable iff (rst)
      quadMode && !csN |=> !hwReset)
      else $error("reset during quad selection");
   no_enable_reset_a: assert property (@(posedge clock) disable iff (rst)
      !config2Volatile[RESET_ENABLE_BIT] [*2] |=> !hwReset)
      else $error("reset while feature disabled");
   hold_line3_a: assert property (@(posedge clock) disable iff (rst)
      csN && st_r.readSeen && quadMode && st_r.holdCnt == 3'h0 |=> !st_r.drv.ioOeN[3] && st_r.drv.ioOut[3])
      else $error("line 3 not held high after read");

   // Read groups launch only from a detected edge of the right kind
   take_edge_a: assert property (@(posedge clock) disable iff (rst)
      txTake |-> $past(fall || (tx.ddr && rise)))
      else $error("read group launched without edge");

   // Double rate reads also launch on the rising edge
   ddr_rise_a: assert property (@(posedge clock) disable iff (rst)
      !csN && tx.readPhase && tx.ddr && rise |=> txTake)
      else $error("double rate group missed on rise");

   // Single rate reads never launch on the capture edge
   sdr_rise_a: assert property (@(posedge clock) disable iff (rst)
      !tx.ddr && rise |=> !txTake)
      else $error("single rate group launched on rise");

   // Single-bit read data leaves on line 1 only
   single_out_a: assert property (@(posedge clock) disable iff (rst)
      tx.readPhase && fall && tx.width == WIDTH_SINGLE |=> drive.ioOeN == 4'hD && drive.ioOut[1] == $past(tx.data[0]))
      else $error("single read not on line 1");

   // Dual read data uses lines 0 and 1, low bit on line 0
   dual_out_a: assert property (@(posedge clock) disable iff (rst)
      tx.readPhase && fall && tx.width == WIDTH_DUAL |=> drive.ioOeN == 4'hC && drive.ioOut[1:0] == $past(tx.data[1:0]))
      else $error("dual read lines wrong");

   // Quad read data in quad mode drives all four lines in bit order
   quad_out_a: assert property (@(posedge clock) disable iff (rst)
      tx.readPhase && fall && tx.width == WIDTH_QUAD && quadMode |=> drive.ioOeN == 4'h0 && drive.ioOut == $past(tx.data))
      else $error("quad read lines wrong");

   // Without quad mode lines 2 and 3 stay released
   quad_off_a: assert property (@(posedge clock) disable iff (rst)
      tx.readPhase && fall && tx.width == WIDTH_QUAD && !quadMode |=> drive.ioOeN[3:2] == 2'b11)
      else $error("upper lines driven outside quad mode");

   // Quad capture takes all four lines
   rx_quad_a: assert property (@(posedge clock) disable iff (rst)
      rise && quadMode |=> rxData == $past(io))
      else $error("quad capture wrong");

   // Narrow capture takes lines 0 and 1 only
   rx_pair_a: assert property (@(posedge clock) disable iff (rst)
      rise && !quadMode |=> rxData[3:2] == 2'b00 && rxData[1:0] == $past(io[1:0]))
      else $error("narrow capture wrong");

   // A deselected device answers nothing
   deselect_quiet_a: assert property (@(posedge clock) disable iff (rst)
      csN |=> !rxValid && !txTake && !wrarAccept && !wrarIgnored)
      else $error("activity while deselected");

   // Deselected and idle means standby power
   standby_power_a: assert property (@(posedge clock) disable iff (rst)
      csN && !embeddedBusy |=> !activePower && !selected)
      else $error("active power while idle");

   // Flag drops once the embedded operation ends
   wip_clear_a: assert property (@(posedge clock) disable iff (rst)
      !embeddedBusy |=> !wipFlag)
      else $error("write-in-progress left set");

   // A qualified reset pulse reaches the output
   hw_reset_a: assert property (@(posedge clock) disable iff (rst)
      resetReq |=> hwReset)
      else $error("qualified reset lost");

   // After a hardware reset a new select fall is needed
   reset_disarm_a: assert property (@(posedge clock) disable iff (rst)
      resetReq |=> !st_r.armed)
      else $error("still armed after reset");

   // A select fall arms command acceptance
   arm_on_fall_a: assert property (@(posedge clock) disable iff (rst)
      st_r.csPrev && !csN && !resetReq |=> st_r.armed)
      else $error("select fall did not arm");

   // Quad mode disables write protection
   wp_quad_a: assert property (@(posedge clock) disable iff (rst)
      wrarStrobe && !csN && quadMode |=> wrarAccept && !wrarIgnored)
      else $error("write blocked in quad mode");

   // Targets outside status and config 1 are never blocked
   wp_open_a: assert property (@(posedge clock) disable iff (rst)
      wrarStrobe && !csN && !wrarStatusTarget |=> wrarAccept && !wrarIgnored)
      else $error("unprotected target blocked");

   // Line 3 is released once the hold time has run out
   hold_end_a: assert property (@(posedge clock) disable iff (rst)
      csN && st_r.holdCnt == 3'(CS_HOLD_DRIVE_CYCLES) |=> st_r.drv.ioOeN == 4'hF && !st_r.readSeen)
      else $error("line 3 held too long");

   // Read output stands between edges
   drive_hold_a: assert property (@(posedge clock) disable iff (rst)
      !csN && tx.readPhase && !fall && !rise |=> $stable(drive))
      else $error("read output changed without edge");

   // Lines are inputs while the host sends
   write_release_a: assert property (@(posedge clock) disable iff (rst)
      !csN && !tx.readPhase |=> drive.ioOeN == 4'hF)
      else $error("driving while host sends");

   // Nothing is accepted before the first select fall
   unarmed_quiet_a: assert property (@(posedge clock) disable iff (rst)
      !st_r.armed |=> !rxValid && !txTake)
      else $error("activity before select fall");

   // Embedded work keeps the device in active power
   busy_active_a: assert property (@(posedge clock) disable iff (rst)
      embeddedBusy |=> activePower)
      else $error("standby during embedded operation");

   // Line 3 hold only applies in quad mode
   hold_quad_only_a: assert property (@(posedge clock) disable iff (rst)
      csN && !quadMode |=> st_r.drv.ioOeN == 4'hF)
      else $error("driving while deselected outside quad");
endmodule : smpi_pin_front

// ### design/smpi_pkg.sv
// Shared types and constants for the multi-I/O serial pin front end.
// Assumes one system clock at 10 MHz; all pins arrive asynchronously.
//
// Behaviour
// - Chip select high: ignore inputs, data outputs released except line 3 held high after a quad read.
// - Write-in-progress flag is 1 during any embedded operation.
// - Chip select low selects the device and enters active power state.
// - Rising serial clock captures instruction, address and data bits.
// - Single-bit reads shift out on falling serial clock.
// - Line 0 captures on rise, drives on fall (SDR) or both edges (DDR).
// - Line 1 captures address/data on rise, drives fall or both edges.
// - Write protect low with disable bit set blocks status/config1 writes silently.
// - Quad enable turns write protect off; pin becomes data line 2.
// - Line-3 pin is reset only if enabled and (not quad or deselected).
// - Quad mode with chip select low: line 3 is data only.
// - Reset recognised after chip select high, pin low, full pulse time.
// - Device drives line 3 high during deselect after quad-mode read data.
// - Reset-enable bit 0 means line-3 pin never resets.
// - Commands open on chip select fall and close on its rise.
// - Lowest bit on line 0; groups sent most significant first.
package smpi_pkg;
   localparam int RESET_PULSE_TIME_NS = 200;
   localparam int CLOCK_PERIOD_NS = 100;
   localparam int RESET_PULSE_CYCLES = (RESET_PULSE_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
   localparam int CS_HOLD_DRIVE_CYCLES = 4;
   localparam logic [7:0] SYNC_RESET = 8'h00;
   localparam int QUAD_ENABLE_BIT = 1;
   localparam int RESET_ENABLE_BIT = 5;
   localparam int STATUS_WRITE_DISABLE_BIT = 7;
   localparam int WIP_BIT = 0;

   typedef enum logic [1:0] {WIDTH_SINGLE, WIDTH_DUAL, WIDTH_QUAD} smpi_width_t;

   // Raw pin inputs, sampled together
   typedef struct packed {
      logic sck;
      logic csN;
      logic [3:0] io;
   } smpi_pins_t;

   // Core-side request for an outgoing group
   typedef struct packed {
      logic readPhase;
      logic ddr;
      smpi_width_t width;
      logic [3:0] data;
   } smpi_tx_t;

   // Pin drivers: output value and active-low enable
   typedef struct packed {
      logic [3:0] ioOut;
      logic [3:0] ioOeN;
   } smpi_drive_t;
endpackage : smpi_pkg

// ### design/smpi_reset_det.sv
// Hardware reset qualifier for the shared line-3 pin.
// Assumes synchronised chip select and pin levels.
`timescale 1ns/1ps
module smpi_reset_det (
   input wire logic clock,
   input wire logic rst,
   input wire logic csN,
   input wire logic pinLevel,
   input wire logic resetEnable,
   input wire logic quadMode,
   output logic resetReq
);
   import smpi_pkg::*;
   typedef struct packed {
      logic [7:0] count;
      logic req;
   } smpi_rdet_st_t;
   smpi_rdet_st_t st_r;
   smpi_rdet_st_t st_nxt;
   logic armed;

   // Quad transfers while selected never look like reset
   assign armed = resetEnable && (!quadMode || csN) && csN;

   // Count synced low samples; restart on select or pin high
   always_comb begin
      st_nxt = st_r;
      st_nxt.req = 1'b0;
      if (!armed || pinLevel) begin
         st_nxt.count = 8'h00;
      end else if (st_r.count < 8'(RESET_PULSE_CYCLES)) begin
         st_nxt.count = st_r.count + 8'h01;
         st_nxt.req = (st_r.count == 8'(RESET_PULSE_CYCLES - 1));
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end
   assign resetReq = st_r.req;

   pulse_len_a: assert property (@(posedge clock) disable iff (rst)
      $rose(st_r.req) |-> $past(armed && !pinLevel, RESET_PULSE_CYCLES))
      else $error("reset recognised before full pulse");
endmodule : smpi_reset_det

// ### design/smpi_sync.sv
// Three-stage synchroniser with agreement filter on the last two stages.
// Assumes input is asynchronous to clock.
`timescale 1ns/1ps
module smpi_sync #(parameter int W = 6) (
   input wire logic clock,
   input wire logic rst,
   input wire logic [W-1:0] async,
   output logic [W-1:0] synced
);
   import smpi_pkg::*;
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] out;
   } smpi_sync_st_t;
   smpi_sync_st_t st_r;
   smpi_sync_st_t st_nxt;

   // Change is accepted only once the second and third stages agree
   always_comb begin
      st_nxt = st_r;
      st_nxt.s1 = async;
      st_nxt.s2 = st_r.s1;
      st_nxt.s3 = st_r.s2;
      for (int i = 0; i < W; i++) begin
         if (st_r.s2[i] == st_r.s3[i]) begin
            st_nxt.out[i] = st_r.s3[i];
         end
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         st_r <= '{default: '1};
      end else begin
         st_r <= st_nxt;
      end
   end
   assign synced = st_r.out;
endmodule : smpi_sync

// ### test/smpi_host_model.sv
// Host controller model: drives clock, select and data pins of one memory.
// Assumes it is the only host on these pins; line 3 is never shared.
`timescale 1ns/1ps
module smpi_host_model (
   input wire logic clock,
   input wire smpi_pkg::smpi_drive_t drive,
   output smpi_pkg::smpi_pins_t pins
);
   import smpi_pkg::*;
   logic sck = 1'b0;
   logic csN = 1'b1;
   logic [3:0] hostOut = 4'hF;
   logic [3:0] hostEn = 4'h0;
   logic [3:0] lastLvl = 4'hF;
   logic [3:0] lvl;

   // Wire level: device first, then host; lines 2/3 pull up, 0/1 float and flip
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         if (!drive.ioOeN[i]) lvl[i] = drive.ioOut[i];
         else if (hostEn[i]) lvl[i] = hostOut[i];
         else if (i >= 2) lvl[i] = 1'b1;
         else lvl[i] = ~lastLvl[i];
      end
   end

   always_ff @(posedge clock) lastLvl <= lvl;
   assign pins = {sck, csN, lvl};

   // Select and data change together, clear of the sampling edge
   task automatic pin_set(input logic c, input logic [3:0] en, input logic [3:0] v);
      @(negedge clock);
      csN = c;
      hostEn = en;
      hostOut = v;
   endtask : pin_set

   // Serial clock half period of 400 ns; stands still between calls
   task automatic sck_edge(input logic v);
      @(negedge clock);
      sck = v;
      repeat (3) @(negedge clock);
   endtask : sck_edge
endmodule : smpi_host_model

// ### test/testbench.sv
// Self-checking bench for the serial pin front end.
// Assumes the host model owns the pins; core-side inputs are driven here.
`timescale 1ns/1ps
module testbench;
   import smpi_pkg::*;
   logic clock = 1'b0;
   logic rst = 1'b1;
   smpi_pins_t pins;
   smpi_drive_t drive;
   smpi_tx_t tx = 8'h00;
   logic [7:0] sr1 = 8'h00;
   logic [7:0] cr1 = 8'h00;
   logic [7:0] cr2 = 8'h00;
   logic busy = 1'b0;
   logic wrTgt = 1'b0;
   logic wrStb = 1'b0;
   logic [3:0] rxData;
   logic rxValid, txTake, selected, activePower, wipFlag, wrarAccept, wrarIgnored, hwReset;
   int bad_count = 0;
   int checks = 0;
   int nRx = 0;
   int nRst = 0;
   int nAcc = 0;
   int nIgn = 0;
   int nTake = 0;

   always #50 clock = ~clock;

   smpi_host_model host (.clock(clock), .drive(drive), .pins(pins));
   smpi_pin_front dut (.clock(clock), .rst(rst), .pins(pins), .tx(tx),
      .status1NonVolatile(sr1), .config1Volatile(cr1), .config2Volatile(cr2),
      .embeddedBusy(busy), .wrarStatusTarget(wrTgt), .wrarStrobe(wrStb), .drive(drive),
      .rxData(rxData), .rxValid(rxValid), .txTake(txTake), .selected(selected),
      .activePower(activePower), .wipFlag(wipFlag), .wrarAccept(wrarAccept),
      .wrarIgnored(wrarIgnored), .hwReset(hwReset));

   // Pulses stand one cycle, so they are tallied at every rising clock edge
   always @(posedge clock) begin
      nRx = nRx + (rxValid === 1'b1);
      nRst = nRst + (hwReset === 1'b1);
      nAcc = nAcc + (wrarAccept === 1'b1);
      nIgn = nIgn + (wrarIgnored === 1'b1);
      nTake = nTake + (txTake === 1'b1);
   end

   task automatic tick(input int n);
      repeat (n) @(negedge clock);
   endtask : tick

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("FAIL %0t got %0h expected %0h", $time, got, exp);
      end
   endtask : chk

   task automatic test_done;
      if (bad_count == 0 && checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : test_done

   // Clock toggles with select high must be ignored
   task automatic t_deselect;
      host.pin_set(1'b1, 4'h1, 4'h1);
      host.sck_edge(1'b1);
      host.sck_edge(1'b0);
      chk(8'(nRx), 8'h00);
      chk(8'(drive.ioOeN), 8'h0F);
      chk(8'(activePower), 8'h00);
   endtask : t_deselect

   task automatic t_capture;
      host.pin_set(1'b0, 4'h1, 4'h1);
      tick(8);
      chk(8'({selected, activePower}), 8'h03);
      host.sck_edge(1'b1);
      tick(3);
      chk(8'(nRx), 8'h01);
      chk(8'(rxData[0]), 8'h01);
   endtask : t_capture

   task automatic t_read;
      nTake = 0;
      tx = {1'b1, 1'b0, WIDTH_SINGLE, 4'hF};
      host.pin_set(1'b0, 4'h1, 4'h0);
      host.sck_edge(1'b0);
      tick(3);
      chk(8'({drive.ioOeN[1], drive.ioOut[1]}), 8'h01);
      chk(8'(nTake), 8'h01);
   endtask : t_read

   // Double rate dual read: one group on the rise, one on the fall
   task automatic t_ddr;
      nTake = 0;
      tx = {1'b1, 1'b1, WIDTH_DUAL, 4'h2};
      host.pin_set(1'b0, 4'h0, 4'hF);
      host.sck_edge(1'b1);
      tick(3);
      chk(8'({drive.ioOeN, 2'b00, drive.ioOut[1:0]}), 8'hC2);
      tx = {1'b1, 1'b1, WIDTH_DUAL, 4'h1};
      host.sck_edge(1'b0);
      tick(3);
      chk(8'({drive.ioOeN, 2'b00, drive.ioOut[1:0]}), 8'hC1);
      chk(8'(nTake), 8'h02);
   endtask : t_ddr

   // Quad read, then line 3 must be held high after deselect
   task automatic t_quad;
      int n;
      n = 0;
      cr1 = 8'h02;
      tx = {1'b1, 1'b0, WIDTH_QUAD, 4'h5};
      host.pin_set(1'b0, 4'h0, 4'hF);
      host.sck_edge(1'b1);
      host.sck_edge(1'b0);
      tick(2);
      chk(8'(drive.ioOeN), 8'h00);
      chk(8'(drive.ioOut), 8'h05);
      host.pin_set(1'b1, 4'h0, 4'hF);
      tx = 8'h00;
      for (int i = 0; i < 14; i++) begin
         @(negedge clock);
         if (drive.ioOeN[3] === 1'b0 && drive.ioOut[3] === 1'b1) n++;
      end
      chk(8'(n), 8'(CS_HOLD_DRIVE_CYCLES));
      chk(8'(drive.ioOeN), 8'h0F);
   endtask : t_quad

   task automatic t_reset;
      cr1 = 8'h00;
      nRst = 0;
      host.pin_set(1'b1, 4'h8, 4'h0);
      tick(10);
      chk(8'(nRst), 8'h00);
      host.pin_set(1'b1, 4'h8, 4'hF);
      tick(6);
      cr2 = 8'h20;
      host.pin_set(1'b1, 4'h8, 4'h0);
      tick(10);
      chk(8'(nRst), 8'h01);
      host.pin_set(1'b1, 4'h8, 4'hF);
      tick(6);
      nRst = 0;
      host.pin_set(1'b1, 4'h8, 4'h0);
      host.pin_set(1'b1, 4'h8, 4'hF);
      tick(8);
      chk(8'(nRst), 8'h00);
      cr1 = 8'h02;
      host.pin_set(1'b0, 4'h8, 4'h0);
      tick(10);
      chk(8'(nRst), 8'h00);
      host.pin_set(1'b1, 4'h8, 4'h0);
      tick(10);
      chk(8'(nRst), 8'h01);
      host.pin_set(1'b1, 4'h8, 4'hF);
      tick(6);
   endtask : t_reset

   // Protect low, protect high, quad on, and a non-status target
   task automatic t_write_any_register_cmd;
      sr1 = 8'h80;
      for (int k = 0; k < 4; k++) begin
         host.pin_set(1'b1, 4'h4, 4'hF);
         tick(6);
         nAcc = 0;
         nIgn = 0;
         cr1 = (k == 2) ? 8'h02 : 8'h00;
         wrTgt = (k != 3);
         host.pin_set(1'b0, 4'h4, {1'b0, k == 1, 2'b00});
         tick(8);
         wrStb = 1'b1;
         tick(1);
         wrStb = 1'b0;
         tick(2);
         chk(8'({nIgn[0], nAcc[0]}), (k == 0) ? 8'h02 : 8'h01);
      end
   endtask : t_write_any_register_cmd

   task automatic t_wip;
      busy = 1'b1;
      host.pin_set(1'b1, 4'h8, 4'hF);
      tick(8);
      chk(8'(wipFlag), 8'h01);
      chk(8'(activePower), 8'h01);
      busy = 1'b0;
      tick(4);
      chk(8'(wipFlag), 8'h00);
   endtask : t_wip

   initial begin
      tick(16);
      rst = 1'b0;
      tick(8);
      t_deselect();
      t_capture();
      t_read();
      t_ddr();
      t_quad();
      t_reset();
      t_write_any_register_cmd();
      t_wip();
      test_done();
   end

   // Whole run needs well under a thousand cycles
   initial begin
      #1000000;
      bad_count++;
      test_done();
   end
endmodule : testbench
